/* bififo_pkg.sv */
// shared constants and carrier types of the bidirectional queue block
package bififo_pkg;
    // data path and queue geometry
    localparam int DATA_W = 36;
    localparam int DEPTH_DEF = 256;
    localparam int BUF_DEPTH_DEF = 16;
    // offset presets loaded by reset
    localparam int EMPTY_PRESET = 8;
    localparam int FULL_PRESET = 8;
    // offset slot layout, also the load order from port a
    localparam int IDX_AB_EMPTY = 0;
    localparam int IDX_BA_EMPTY = 1;
    localparam int IDX_AB_FULL = 2;
    localparam int IDX_BA_FULL = 3;
    localparam int LOAD_WORDS = 4;

    // block mode after reset
    typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_RUN} mode_t;

    // one port's control pins
    typedef struct packed {
        logic chip_select_n;
        logic direction;
        logic transfer_strobe;
        logic mailbox_select;
    } port_ctl_t;

    // one port's status flags
    typedef struct packed {
        logic space_flag;
        logic near_full_n;
        logic output_valid;
        logic near_empty_n;
        logic mail_tx_flag;
        logic mail_rx_flag;
    } port_flags_t;
endpackage

/* bidir_fifo_flags_mailbox.sv */
// two opposite queues with flag logic, offset loading and two mailboxes
//
// Behaviour
// - near-full flag is computed on the writing side of each queue.
// - near-full goes low when stored count reaches depth minus offset.
// - near-full is high while count is at most depth minus offset minus one.
// - after a read, near-full rises on the second writing-side edge.
// - an edge too close to the read does not count as first sync edge.
// - offsets preset on reset, or loaded from port a.
// - first word falls to output register unasked; it leaves the count.
// - fetching a word into the output register frees its location.
// - b-to-a flags: empty both low, up to offset valid only, above both high.
// - near-full low from depth minus offset; space low at full depth and outside run mode.
// - one 36-bit mailbox per direction bypasses the queues.
// - port a mailbox write stores the data into the a-to-b mailbox.
// - port b mailbox write stores the data into the b-to-a mailbox.
// - mailbox write drives its flag low; writes ignored while low.
// - driven bus shows queue output or mailbox, chosen by mailbox select.
// - port b mailbox read sets the a-to-b mail flag high.
// - port a mailbox read sets the b-to-a mail flag high.
// - reading a mailbox keeps its contents; only writes change it.
// - first word reaches output within three reading-side edges.
// - space flag returns after a read frees a full queue.
// - port a read pops queue or reads mailbox; deselected bus floats.
// - writes into a full queue are ignored.
`timescale 1ns/1ps

module dir_queue #(
    parameter int WIDTH = bififo_pkg::DATA_W,
    parameter int DEPTH = bififo_pkg::BUF_DEPTH_DEF
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // filling side
    input wire logic wr_valid_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    output logic wr_ready_o,
    output logic near_full_n_o,
    input wire logic [$clog2(DEPTH)-1:0] full_off_i,
    // draining side
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic near_empty_n_o,
    input wire logic [$clog2(DEPTH)-1:0] empty_off_i
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW-1:0] wsync1;
        logic [PW-1:0] wsync2;
        logic [PW-1:0] rsync1;
        logic [PW-1:0] rsync2;
        logic out_valid;
        logic [WIDTH-1:0] out_word;
    } q_state_t;

    q_state_t q_reg;
    q_state_t q_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] cnt_wr;
    logic [PW-1:0] cnt_rd;
    logic do_write;
    logic do_pop;
    logic do_fetch;

    // pointer arithmetic needs a power of two
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("dir_queue: DEPTH must be a power of two, at least 4");
    end

    // each side sees the far pointer only after two stages
    always_comb
    begin
        q_next = q_reg;
        cnt_wr = q_reg.wptr - q_reg.rsync2;
        cnt_rd = q_reg.wsync2 - q_reg.rptr;
        do_write = wr_valid_i && (cnt_wr != FULL_CNT);
        do_pop = rd_ready_i && q_reg.out_valid;
        do_fetch = (!q_reg.out_valid || do_pop) && (cnt_rd != '0);
        if (do_write)
        begin
            q_next.wptr = q_reg.wptr + 1'b1;
        end
        if (do_pop)
        begin
            q_next.out_valid = 1'b0;
        end
        // fetch moves the word out of memory, freeing its slot
        if (do_fetch)
        begin
            q_next.out_word = mem[q_reg.rptr[AW-1:0]];
            q_next.out_valid = 1'b1;
            q_next.rptr = q_reg.rptr + 1'b1;
        end
        // stage 1 feeds only stage 2, never any compare
        q_next.wsync1 = q_reg.wptr;
        q_next.wsync2 = q_reg.wsync1;
        q_next.rsync1 = q_reg.rptr;
        q_next.rsync2 = q_reg.rsync1;
    end

    // state register, frozen while the enable is low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q_reg <= '0;
        end
        else if (ce_i)
        begin
            q_reg <= q_next;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (ce_i && do_write)
        begin
            mem[q_reg.wptr[AW-1:0]] <= wr_data_i;
        end
    end

    // flags from synchronised counts; the late edge just adds a cycle
    assign wr_ready_o = (cnt_wr != FULL_CNT);
    assign near_full_n_o = (cnt_wr < (FULL_CNT - {1'b0, full_off_i}));
    assign rd_valid_o = q_reg.out_valid;
    assign rd_data_o = q_reg.out_word;
    assign near_empty_n_o = (cnt_rd > {1'b0, empty_off_i});

    a_full_ignore: assert property (
        @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        (wr_valid_i && !wr_ready_o) |=> (q_reg.wptr == $past(q_reg.wptr)))
        else $error("write into full queue moved the write pointer");
    a_fall_through: assert property (
        @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        (do_write && q_reg.wptr == q_reg.rptr && q_reg.wptr == q_reg.wsync2 && !q_reg.out_valid && !rd_ready_i)
        |=> !rd_valid_o [*3] ##1 rd_valid_o)
        else $error("first word did not fall through on the third edge");
    a_near_full_rise: assert property (
        @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        (do_fetch && !do_write && q_reg.rptr == q_reg.rsync2 && cnt_wr == FULL_CNT - {1'b0, full_off_i})
        |=> !near_full_n_o ##1 !near_full_n_o ##1 (near_full_n_o || $past(do_write) || $past(do_write, 2)))
        else $error("near-full flag did not rise on the second edge");
endmodule

module bidir_fifo_flags_mailbox #(
    parameter int DEPTH = bififo_pkg::DEPTH_DEF
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // strap: load offsets from port a after reset
    input wire logic offset_program_i,
    // port a
    input wire bififo_pkg::port_ctl_t port_a_ctl_i,
    input wire logic [bififo_pkg::DATA_W-1:0] port_a_data_i,
    output logic [bififo_pkg::DATA_W-1:0] port_a_data_o,
    output logic port_a_data_oe_n_o,
    output bififo_pkg::port_flags_t port_a_flags_o,
    // port b
    input wire bififo_pkg::port_ctl_t port_b_ctl_i,
    input wire logic [bififo_pkg::DATA_W-1:0] port_b_data_i,
    output logic [bififo_pkg::DATA_W-1:0] port_b_data_o,
    output logic port_b_data_oe_n_o,
    output bififo_pkg::port_flags_t port_b_flags_o
);
    localparam int DW = bififo_pkg::DATA_W;
    localparam int OW = $clog2(DEPTH);

    typedef struct packed {
        bififo_pkg::mode_t mode;
        logic [1:0] ld_cnt;
        logic mf_ab;
        logic mf_ba;
        logic [DW-1:0] mail_ab;
        logic [DW-1:0] mail_ba;
        logic [bififo_pkg::LOAD_WORDS-1:0][OW-1:0] ofs;
    } top_state_t;

    localparam top_state_t ST_RST = '{
        mode: bififo_pkg::ST_INIT,
        ld_cnt: '0,
        mf_ab: 1'b1,
        mf_ba: 1'b1,
        mail_ab: '0,
        mail_ba: '0,
        ofs: {OW'(bififo_pkg::FULL_PRESET), OW'(bififo_pkg::FULL_PRESET),
              OW'(bififo_pkg::EMPTY_PRESET), OW'(bififo_pkg::EMPTY_PRESET)}
    };

    top_state_t s_reg;
    top_state_t s_next;
    logic rst_meta;
    logic rst_n;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic ab_mail_wr;
    logic ba_mail_wr;
    logic ab_rdy;
    logic ba_rdy;
    logic ab_valid;
    logic ba_valid;
    logic [DW-1:0] ab_word;
    logic [DW-1:0] ba_word;

    // presets must fit the queue depth
    if (DEPTH < 4 || bififo_pkg::FULL_PRESET >= DEPTH || bififo_pkg::EMPTY_PRESET >= DEPTH)
    begin : g_bad_cfg
        $error("bidir_fifo_flags_mailbox: DEPTH too small for offset presets");
    end

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // port decode; transfers need select low and strobe high
    assign a_wr = !port_a_ctl_i.chip_select_n && port_a_ctl_i.transfer_strobe && port_a_ctl_i.direction;
    assign a_rd = !port_a_ctl_i.chip_select_n && port_a_ctl_i.transfer_strobe && !port_a_ctl_i.direction;
    assign b_wr = !port_b_ctl_i.chip_select_n && port_b_ctl_i.transfer_strobe && !port_b_ctl_i.direction;
    assign b_rd = !port_b_ctl_i.chip_select_n && port_b_ctl_i.transfer_strobe && port_b_ctl_i.direction;
    // mailbox writes only while the flag says empty
    assign ab_mail_wr = a_wr && port_a_ctl_i.mailbox_select && s_reg.mf_ab;
    assign ba_mail_wr = b_wr && port_b_ctl_i.mailbox_select && s_reg.mf_ba;

    // mode, offset load and mailboxes
    always_comb
    begin
        s_next = s_reg;
        case (s_reg.mode)
            bififo_pkg::ST_INIT:
            begin
                // strap caught on the first edge after release
                s_next.mode = offset_program_i ? bififo_pkg::ST_LOAD : bififo_pkg::ST_RUN;
            end
            bififo_pkg::ST_LOAD:
            begin
                // one offset per port a queue write, gaps allowed
                if (a_wr && !port_a_ctl_i.mailbox_select)
                begin
                    s_next.ofs[s_reg.ld_cnt] = port_a_data_i[OW-1:0];
                    s_next.ld_cnt = s_reg.ld_cnt + 1'b1;
                    if (s_reg.ld_cnt == 2'(bififo_pkg::LOAD_WORDS - 1))
                    begin
                        s_next.mode = bififo_pkg::ST_RUN;
                    end
                end
            end
            bififo_pkg::ST_RUN:
            begin
                s_next.mode = bififo_pkg::ST_RUN;
            end
            default:
            begin
                s_next.mode = bififo_pkg::ST_INIT;
            end
        endcase
        // a read sets the flag; a write in the same cycle wins so mail is not lost
        if (b_rd && port_b_ctl_i.mailbox_select)
        begin
            s_next.mf_ab = 1'b1;
        end
        if (ab_mail_wr)
        begin
            s_next.mail_ab = port_a_data_i;
            s_next.mf_ab = 1'b0;
        end
        if (a_rd && port_a_ctl_i.mailbox_select)
        begin
            s_next.mf_ba = 1'b1;
        end
        if (ba_mail_wr)
        begin
            s_next.mail_ba = port_b_data_i;
            s_next.mf_ba = 1'b0;
        end
    end

    // state register, reset to presets and empty mailboxes
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= ST_RST;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    // a-to-b queue, written by port a and drained by port b
    dir_queue #(
        .WIDTH(DW),
        .DEPTH(DEPTH)
    ) u_ab (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .wr_valid_i(a_wr && !port_a_ctl_i.mailbox_select && s_reg.mode == bififo_pkg::ST_RUN),
        .wr_data_i(port_a_data_i),
        .wr_ready_o(ab_rdy),
        .near_full_n_o(port_a_flags_o.near_full_n),
        .full_off_i(s_reg.ofs[bififo_pkg::IDX_AB_FULL]),
        .rd_valid_o(ab_valid),
        .rd_ready_i(b_rd && !port_b_ctl_i.mailbox_select),
        .rd_data_o(ab_word),
        .near_empty_n_o(port_b_flags_o.near_empty_n),
        .empty_off_i(s_reg.ofs[bififo_pkg::IDX_AB_EMPTY])
    );

    // b-to-a queue, written by port b and drained by port a
    dir_queue #(
        .WIDTH(DW),
        .DEPTH(DEPTH)
    ) u_ba (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .wr_valid_i(b_wr && !port_b_ctl_i.mailbox_select && s_reg.mode == bififo_pkg::ST_RUN),
        .wr_data_i(port_b_data_i),
        .wr_ready_o(ba_rdy),
        .near_full_n_o(port_b_flags_o.near_full_n),
        .full_off_i(s_reg.ofs[bififo_pkg::IDX_BA_FULL]),
        .rd_valid_o(ba_valid),
        .rd_ready_i(a_rd && !port_a_ctl_i.mailbox_select),
        .rd_data_o(ba_word),
        .near_empty_n_o(port_a_flags_o.near_empty_n),
        .empty_off_i(s_reg.ofs[bififo_pkg::IDX_BA_EMPTY])
    );

    // space flags hold low until offsets are loaded
    assign port_a_flags_o.space_flag = ab_rdy && (s_reg.mode == bififo_pkg::ST_RUN);
    assign port_a_flags_o.output_valid = ba_valid;
    assign port_a_flags_o.mail_tx_flag = s_reg.mf_ab;
    assign port_a_flags_o.mail_rx_flag = s_reg.mf_ba;
    assign port_b_flags_o.space_flag = ba_rdy && (s_reg.mode == bififo_pkg::ST_RUN);
    assign port_b_flags_o.output_valid = ab_valid;
    assign port_b_flags_o.mail_tx_flag = s_reg.mf_ba;
    assign port_b_flags_o.mail_rx_flag = s_reg.mf_ab;

    // bus drivers; select is a pin, the words are register outputs
    assign port_a_data_o = port_a_ctl_i.mailbox_select ? s_reg.mail_ba : ba_word;
    assign port_b_data_o = port_b_ctl_i.mailbox_select ? s_reg.mail_ab : ab_word;
    assign port_a_data_oe_n_o = port_a_ctl_i.chip_select_n || port_a_ctl_i.direction;
    assign port_b_data_oe_n_o = port_b_ctl_i.chip_select_n || !port_b_ctl_i.direction;

    a_mail_store: assert property (
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        ab_mail_wr |=> (s_reg.mail_ab == $past(port_a_data_i)) && !s_reg.mf_ab)
        else $error("a-to-b mailbox write not stored");
    a_mail_lock: assert property (
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        (!s_reg.mf_ba && b_wr && port_b_ctl_i.mailbox_select) |=> $stable(s_reg.mail_ba))
        else $error("b-to-a mailbox changed while its flag was low");
    a_mail_keep: assert property (
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        (a_rd && port_a_ctl_i.mailbox_select && !ba_mail_wr) |=> $stable(s_reg.mail_ba) && s_reg.mf_ba)
        else $error("b-to-a mailbox read changed contents or left flag low");
    a_mail_set_b: assert property (
        @(posedge clk_i) disable iff (!rst_n || !ce_i)
        (b_rd && port_b_ctl_i.mailbox_select && !ab_mail_wr) |=> port_b_flags_o.mail_rx_flag)
        else $error("a-to-b mail flag not set by port b read");
    a_bus_select: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (!port_b_data_oe_n_o && !port_b_ctl_i.mailbox_select) |-> port_b_data_o == ab_word)
        else $error("port b bus not showing queue output");
    a_bus_float: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        port_a_ctl_i.chip_select_n |-> port_a_data_oe_n_o)
        else $error("port a drives bus while deselected");
endmodule

/* port_agent.sv */
// behavioural processor standing at one port of the queue block
`timescale 1ns/1ps
module port_agent #(
    parameter logic WR_DIR = 1'b1
) (
    // clock
    input wire logic clk_i,
    // pins toward the block
    output bififo_pkg::port_ctl_t ctl_o,
    output logic [bififo_pkg::DATA_W-1:0] data_o,
    input wire logic [bififo_pkg::DATA_W-1:0] data_i
);
    // idle: deselected, bus shows junk rather than stale data
    initial
    begin
        ctl_o = '{1'b1, ~WR_DIR, 1'b0, 1'b0};
        data_o = 36'hf_0f0f_0f0f;
    end

    // one transfer, held from one edge to the taking edge
    task automatic op(input logic wr, input logic mbx, input logic [35:0] d, output logic [35:0] q);
        @(posedge clk_i);
        ctl_o <= '{1'b0, wr ? WR_DIR : ~WR_DIR, 1'b1, mbx};
        if (wr)
            data_o <= d;
        // read data is taken at the same edge that takes the request
        @(posedge clk_i);
        q = data_i;
        ctl_o <= '{1'b1, ~WR_DIR, 1'b0, 1'b0};
        data_o <= ~data_o; // released bus no longer holds the word
    endtask
endmodule

/* tb.sv */
// self-checking bench for the flags and mailboxes of the two-way queue
`timescale 1ns/1ps
module tb;
    localparam int DEPTH = 16;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic offset_program_i = 1'b0;
    logic ce_i = 1'b1;
    bififo_pkg::port_ctl_t pa_ctl;
    bififo_pkg::port_ctl_t pb_ctl;
    logic [35:0] pa_din;
    logic [35:0] pa_dout;
    logic [35:0] pb_din;
    logic [35:0] pb_dout;
    logic pa_oe_n;
    logic pb_oe_n;
    bififo_pkg::port_flags_t fa;
    bififo_pkg::port_flags_t fb;
    int err_count = 0;
    int checks = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    bidir_fifo_flags_mailbox #(.DEPTH(DEPTH)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .offset_program_i(offset_program_i),
        .port_a_ctl_i(pa_ctl), .port_a_data_i(pa_din), .port_a_data_o(pa_dout),
        .port_a_data_oe_n_o(pa_oe_n), .port_a_flags_o(fa),
        .port_b_ctl_i(pb_ctl), .port_b_data_i(pb_din), .port_b_data_o(pb_dout),
        .port_b_data_oe_n_o(pb_oe_n), .port_b_flags_o(fb)
    );
    port_agent #(.WR_DIR(1'b1)) pa (.clk_i(clk_i), .ctl_o(pa_ctl), .data_o(pa_din), .data_i(pa_dout));
    port_agent #(.WR_DIR(1'b0)) pb (.clk_i(clk_i), .ctl_o(pb_ctl), .data_o(pb_din), .data_i(pb_dout));

    // compare and count
    task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset with the given strap, then look at the idle flags
    task automatic do_reset(input logic strap);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        offset_program_i <= strap;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        chk("mail_a", 1, fa.mail_tx_flag);
        chk("mail_b", 1, fb.mail_tx_flag);
        chk("valid_a", 0, fa.output_valid);
        chk("nempty_a", 0, fa.near_empty_n);
        chk("nfull_b", 1, fb.near_full_n);
        chk("space_b", !strap, fb.space_flag);
        chk("oe_idle", 1, pa_oe_n);
        chk("oe_idle_b", 1, pb_oe_n);
    endtask

    // mailbox both ways; a-to-b also: refused second write, read keeps contents
    task automatic t_mail();
        logic [35:0] q;
        pa.op(1'b1, 1'b1, 36'h9_a5a5_0f0f, q);
        #1;
        chk("mbf_ab_a", 0, fa.mail_tx_flag);
        chk("mbf_ab_b", 0, fb.mail_rx_flag);
        pa.op(1'b1, 1'b1, 36'h1_2345_6789, q);
        pb.op(1'b0, 1'b1, 36'h0, q);
        chk("mail_ab", 36'h9_a5a5_0f0f, q);
        #1;
        chk("mbf_ab_free", 1, fb.mail_rx_flag);
        fork
            pb.op(1'b0, 1'b1, 36'h0, q);
            begin
                @(posedge clk_i);
                @(negedge clk_i);
                chk("oe_b_read", 0, pb_oe_n);
            end
        join
        chk("mail_ab_kept", 36'h9_a5a5_0f0f, q);
        pb.op(1'b1, 1'b1, 36'h0_0ff0_ff00, q);
        #1;
        chk("mbf_ba", 0, fa.mail_rx_flag);
        chk("mbf_ba_b", 0, fb.mail_tx_flag);
        fork
            pa.op(1'b0, 1'b1, 36'h0, q);
            begin
                @(posedge clk_i);
                @(negedge clk_i);
                chk("oe_a_read", 0, pa_oe_n);
            end
        join
        chk("mail_ba", 36'h0_0ff0_ff00, q);
        #1;
        chk("mbf_ba_free", 1, fa.mail_rx_flag);
    endtask

    // enable low: a mailbox write is not taken and no flag moves
    task automatic t_freeze();
        logic [35:0] q;
        @(posedge clk_i);
        ce_i <= 1'b0;
        pa.op(1'b1, 1'b1, 36'h5_5555_aaaa, q);
        #1;
        chk("frozen_mbf", 1, fa.mail_tx_flag);
        @(posedge clk_i);
        ce_i <= 1'b1;
    endtask

    // fill one queue past full, then drain it, checking all four flags
    task automatic t_fill(input bit ab, input int xe, input int yf);
        logic [35:0] q;
        int n;
        bififo_pkg::port_flags_t wf;
        bififo_pkg::port_flags_t rf;
        for (int i = 0; i <= DEPTH + 1; i++)
        begin
            if (ab)
                pa.op(1'b1, 1'b0, 36'(i), q);
            else
                pb.op(1'b1, 1'b0, 36'(i), q);
            repeat (3) @(posedge clk_i);
            #1;
            wf = ab ? fa : fb;
            rf = ab ? fb : fa;
            n = (i > DEPTH) ? DEPTH : i; // first word sits in the output register
            chk("valid", 1, rf.output_valid);
            chk("nempty", n > xe, rf.near_empty_n);
            chk("nfull", n < DEPTH - yf, wf.near_full_n);
            chk("space", n < DEPTH, wf.space_flag);
        end
        for (int j = 0; j <= DEPTH; j++)
        begin
            if (ab)
                pb.op(1'b0, 1'b0, 36'h0, q);
            else
                pa.op(1'b0, 1'b0, 36'h0, q);
            chk("data", 36'(j), q);
            n = (j < DEPTH) ? DEPTH - 1 - j : 0;
            #1;
            wf = ab ? fa : fb;
            if (n == DEPTH - yf - 1)
                chk("nfull_hold", 0, wf.near_full_n);
            repeat (4) @(posedge clk_i);
            #1;
            wf = ab ? fa : fb;
            rf = ab ? fb : fa;
            chk("valid_d", j < DEPTH, rf.output_valid);
            chk("nempty_d", n > xe, rf.near_empty_n);
            chk("nfull_d", n < DEPTH - yf, wf.near_full_n);
            chk("space_d", 1, wf.space_flag);
        end
    endtask

    // offsets loaded from port a with gaps, then both queues rechecked
    task automatic t_program();
        logic [35:0] q;
        do_reset(1'b1);
        pa.op(1'b1, 1'b0, 36'h2, q);
        repeat (3) @(posedge clk_i);
        pa.op(1'b1, 1'b0, 36'h3, q);
        pa.op(1'b1, 1'b0, 36'h4, q);
        pa.op(1'b1, 1'b0, 36'h5, q);
        repeat (2) @(posedge clk_i);
        #1;
        chk("space_run", 1, fa.space_flag);
        t_fill(1'b1, 2, 4);
        t_fill(1'b0, 3, 5);
    endtask

    // main sequence
    initial
    begin
        do_reset(1'b0);
        t_mail();
        t_freeze();
        t_fill(1'b1, bififo_pkg::EMPTY_PRESET, bififo_pkg::FULL_PRESET);
        t_fill(1'b0, bififo_pkg::EMPTY_PRESET, bififo_pkg::FULL_PRESET);
        t_program();
        conclude();
    end

    // watchdog, well beyond the roughly 800 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end
endmodule
